/* File: logic/hlp_consts.svh */
// Constants of the link procedure engine: sequence width, timers, retry count.
// Assumes a single 50 MHz core clock; included by its bare name.
`ifndef HLP_CONSTS_SVH
`define HLP_CONSTS_SVH

`define HLP_SEQ_W 7
`define HLP_CLK_KHZ 50000
`define HLP_T1_MS 1500
`define HLP_T4_MS 2000
`define HLP_T1_CYC (`HLP_T1_MS * `HLP_CLK_KHZ)
`define HLP_T4_CYC (`HLP_T4_MS * `HLP_CLK_KHZ)
`define HLP_TMR_W 27
`define HLP_N2_DEF 4
`define HLP_RETRY_W 4
`define HLP_LEN_W 16
// FRMR capability bits {SREJ, UI, REJ}
`define HLP_FRMR_CAPS 3'h4
`define HLP_FIFO_DEPTH 2

`endif

/* File: logic/hlp_pkg.sv */
// Types of the link procedure engine: frame kinds, states, frame carriers.
// Assumes hlp_consts.svh is on the include path.
`default_nettype none
`include "hlp_consts.svh"

package hlp_pkg;

  typedef enum logic [3:0] {
    FR_I = 4'h0,
    FR_RR = 4'h1,
    FR_RNR = 4'h2,
    FR_REJ = 4'h3,
    FR_SREJ = 4'h4,
    FR_SABME = 4'h5,
    FR_SABM = 4'h6,
    FR_DISC = 4'h7,
    FR_UA = 4'h8,
    FR_DM = 4'h9,
    FR_FRMR = 4'hA,
    FR_UI = 4'hB
  } hlp_kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_INFO = 3'h2,
    ST_DISCW = 3'h3,
    ST_DOWN = 3'h4
  } hlp_state_e;

  typedef logic [`HLP_SEQ_W-1:0] hlp_seq_t;

  typedef struct packed {
    hlp_kind_e kind;
    logic cmd;
    logic pf;
    hlp_seq_t ns;
    hlp_seq_t nr;
    logic [`HLP_LEN_W-1:0] lenBits;
  } hlp_rx_s;

  typedef struct packed {
    hlp_kind_e kind;
    logic cmd;
    logic pf;
    hlp_seq_t ns;
    hlp_seq_t nr;
    logic [2:0] frmrCaps;
  } hlp_tx_s;

  typedef struct packed {
    hlp_state_e st;
    hlp_seq_t vs;
    hlp_seq_t va;
    hlp_seq_t vr;
    logic [`HLP_RETRY_W-1:0] retry;
    logic t1Run;
    logic [`HLP_TMR_W-1:0] t1Cnt;
    logic [`HLP_TMR_W-1:0] t4Cnt;
    logic ackPend;
    logic srejSent;
    logic peerBusy;
    logic relPulse;
    logic dropPulse;
    hlp_tx_s [`HLP_FIFO_DEPTH-1:0] buffer;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
  } hlp_state_s;

endpackage

`default_nettype wire

/* File: logic/hlp_link_ctrl.sv */
// Balanced link procedure engine: set-up, I frame transfer, SREJ recovery,
// frame reject and disconnection. Frames are exchanged as descriptors;
// framing, stuffing and payload storage live outside this block.
// Contract
// - Only the calling end opens the link; the called end waits for SABME.
// - Link set-up uses SABME only; SABM is never sent.
// - After link up or disconnection, never attempt set-up again.
// - Never send SABME during information transfer.
// - SABME received during transfer: send DISC, then release the bearer; the code raises bearerRelease once the DISC is queued, not after it is taken.
// - Accept response I frames with final bit set.
// - Sender of DISC may optionally release the bearer itself.
// - DM is only sent as a reply to a received command.
// - No modulo 8 numbering; only extended numbering.
// - Acknowledge accepted I frames at once, no later than T2.
// - Out-of-sequence I frames are recovered with SREJ, not REJ.
// - Never send REJ; a received REJ is answered with FRMR.
// - In waiting, busy states recover frames only by selective reject.
// - No link reset; reset conditions lead to disconnection.
// - Count retransmissions and give up at N2.
// - Never more than k unacknowledged I frames outstanding.
// - I frames longer than N1 bits are invalid.
// - Keep-alive timer T4 is optional and configurable.
// - Received FRMR is answered with DISC, never a reset.
// - FRMR field marks REJ and UI unimplemented, SREJ implemented.
// - T1 defaults to 1.5 seconds.
// - N2 defaults to 4.
`default_nettype none
`include "hlp_consts.svh"

module hlp_link_ctrl #(
  parameter int unsigned T1_CYCLES = `HLP_T1_CYC,
  parameter int unsigned T4_CYCLES = `HLP_T4_CYC,
  parameter int unsigned N2_MAX = `HLP_N2_DEF
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic isCaller,
  input wire logic openReq,
  input wire logic closeReq,
  input wire logic relOnDisc,
  input wire logic t4Enable,
  input wire hlp_pkg::hlp_seq_t windowK,
  input wire logic [`HLP_LEN_W-1:0] n1Max,
  input wire logic rxValid,
  input wire hlp_pkg::hlp_rx_s rxFrame,
  output logic rxReady,
  input wire logic txReqValid,
  input wire logic [`HLP_LEN_W-1:0] txReqLen,
  output logic txReqReady,
  output logic txValid,
  output hlp_pkg::hlp_tx_s txFrame,
  input wire logic txReady,
  output logic linkUp,
  output logic linkDown,
  output logic bearerRelease,
  output logic reqDropped
);

  hlp_pkg::hlp_state_s q;
  hlp_pkg::hlp_state_s d;

  localparam logic [`HLP_TMR_W-1:0] T1_LOAD = `HLP_TMR_W'(T1_CYCLES - 1);
  localparam logic [`HLP_TMR_W-1:0] T4_LOAD = `HLP_TMR_W'(T4_CYCLES - 1);
  localparam logic [`HLP_RETRY_W-1:0] N2_LIM = `HLP_RETRY_W'(N2_MAX);

  // Modulo 128 distance from a to b
  function automatic hlp_pkg::hlp_seq_t seqDiff(input hlp_pkg::hlp_seq_t b,
                                                input hlp_pkg::hlp_seq_t a);
    seqDiff = b - a;
  endfunction

  function automatic hlp_pkg::hlp_tx_s mkFrame(input hlp_pkg::hlp_kind_e kind,
                                               input logic cmd, input logic pf,
                                               input hlp_pkg::hlp_seq_t ns,
                                               input hlp_pkg::hlp_seq_t nr);
    hlp_pkg::hlp_tx_s f;
    f.kind = kind;
    f.cmd = cmd;
    f.pf = pf;
    f.ns = ns;
    f.nr = nr;
    f.frmrCaps = (kind == hlp_pkg::FR_FRMR) ? `HLP_FRMR_CAPS : 3'h0;
    mkFrame = f;
  endfunction

  logic room;
  logic pop;
  logic push;
  logic t1Exp;
  logic t4Exp;
  logic winOpen;
  logic ackOk;
  hlp_pkg::hlp_tx_s pushFrame;

  assign room = q.count != 2'h2;
  assign pop = txValid && txReady;
  assign t1Exp = q.t1Run && (q.t1Cnt == '0);
  assign t4Exp = t4Enable && (q.t4Cnt == '0);
  assign winOpen = seqDiff(q.vs, q.va) < windowK;
  assign ackOk = seqDiff(rxFrame.nr, q.va) <= seqDiff(q.vs, q.va);

  // The receive path and the request path both stall on a full buffer
  assign rxReady = room;
  assign txReqReady = room && !rxValid && (q.st == hlp_pkg::ST_INFO) && !closeReq
                      && !t1Exp && !q.ackPend && winOpen && !q.peerBusy;
  assign txValid = q.count != 2'h0;
  assign txFrame = q.buffer[q.rdPtr];
  assign linkUp = q.st == hlp_pkg::ST_INFO;
  assign linkDown = q.st == hlp_pkg::ST_DOWN;
  assign bearerRelease = q.relPulse;
  assign reqDropped = q.dropPulse;

  always_comb begin
    d = q;
    d.relPulse = 1'b0;
    d.dropPulse = 1'b0;
    push = 1'b0;
    pushFrame = '0;
    if (q.t1Run && q.t1Cnt != '0) begin
      d.t1Cnt = q.t1Cnt - 1'b1;
    end
    if (q.st == hlp_pkg::ST_INFO && t4Enable && q.t4Cnt != '0) begin
      d.t4Cnt = q.t4Cnt - 1'b1;
    end
    if (room && rxValid) begin
      d.t4Cnt = T4_LOAD;
      unique case (q.st)
        hlp_pkg::ST_IDLE: begin
          if (!isCaller && rxFrame.cmd && rxFrame.kind == hlp_pkg::FR_SABME) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_UA, 1'b0, rxFrame.pf, '0, '0);
            d.st = hlp_pkg::ST_INFO;
            d.vs = '0;
            d.va = '0;
            d.vr = '0;
          end else if (rxFrame.cmd) begin
            // Basic-mode SABM and early commands are refused by a solicited DM
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_DM, 1'b0, rxFrame.pf, '0, '0);
          end
        end
        hlp_pkg::ST_SETUP: begin
          if (!rxFrame.cmd && rxFrame.kind == hlp_pkg::FR_UA) begin
            d.st = hlp_pkg::ST_INFO;
            d.t1Run = 1'b0;
            d.retry = '0;
            d.vs = '0;
            d.va = '0;
            d.vr = '0;
            d.t4Cnt = T4_LOAD;
          end else if (!rxFrame.cmd && rxFrame.kind == hlp_pkg::FR_DM) begin
            d.st = hlp_pkg::ST_DOWN;
            d.t1Run = 1'b0;
          end
        end
        hlp_pkg::ST_INFO: begin
          if (rxFrame.kind == hlp_pkg::FR_I && rxFrame.lenBits > n1Max) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_FRMR, 1'b0, rxFrame.pf, q.vs, q.vr);
          end else begin
            unique case (rxFrame.kind)
              hlp_pkg::FR_SABME: begin
                push = 1'b1;
                pushFrame = mkFrame(hlp_pkg::FR_DISC, 1'b1, 1'b1, '0, '0);
                d.relPulse = 1'b1;
                d.st = hlp_pkg::ST_DISCW;
                d.t1Run = 1'b1;
                d.t1Cnt = T1_LOAD;
              end
              hlp_pkg::FR_REJ: begin
                push = 1'b1;
                pushFrame = mkFrame(hlp_pkg::FR_FRMR, 1'b0, rxFrame.pf, q.vs, q.vr);
              end
              hlp_pkg::FR_FRMR: begin
                push = 1'b1;
                pushFrame = mkFrame(hlp_pkg::FR_DISC, 1'b1, 1'b1, '0, '0);
                d.st = hlp_pkg::ST_DISCW;
                d.t1Run = 1'b1;
                d.t1Cnt = T1_LOAD;
              end
              hlp_pkg::FR_DISC: begin
                push = 1'b1;
                pushFrame = mkFrame(hlp_pkg::FR_UA, 1'b0, rxFrame.pf, '0, '0);
                d.st = hlp_pkg::ST_DOWN;
                d.t1Run = 1'b0;
              end
              hlp_pkg::FR_I, hlp_pkg::FR_RR, hlp_pkg::FR_RNR: begin
                // Response I frames with F=1 are taken like any other
                if (ackOk) begin
                  d.va = rxFrame.nr;
                  if (rxFrame.nr != q.va) begin
                    d.retry = '0;
                  end
                  d.t1Run = rxFrame.nr != q.vs;
                  d.t1Cnt = T1_LOAD;
                end
                if (rxFrame.kind == hlp_pkg::FR_I) begin
                  if (rxFrame.ns == q.vr) begin
                    d.vr = q.vr + 1'b1;
                    d.ackPend = 1'b1;
                    d.srejSent = 1'b0;
                  end else if (!q.srejSent) begin
                    push = 1'b1;
                    pushFrame = mkFrame(hlp_pkg::FR_SREJ, 1'b0, 1'b0, '0, q.vr);
                    d.srejSent = 1'b1;
                  end
                end else begin
                  d.peerBusy = rxFrame.kind == hlp_pkg::FR_RNR;
                  if (rxFrame.cmd && rxFrame.pf) begin
                    push = 1'b1;
                    pushFrame = mkFrame(hlp_pkg::FR_RR, 1'b0, 1'b1, '0, q.vr);
                    d.ackPend = 1'b0;
                  end
                end
              end
              hlp_pkg::FR_SREJ: begin
                // Selective retransmission of the one frame asked for
                push = 1'b1;
                pushFrame = mkFrame(hlp_pkg::FR_I, 1'b1, 1'b0, rxFrame.nr, q.vr);
                d.ackPend = 1'b0;
              end
              default: begin
                if (rxFrame.cmd) begin
                  push = 1'b1;
                  pushFrame = mkFrame(hlp_pkg::FR_FRMR, 1'b0, rxFrame.pf, q.vs, q.vr);
                end
              end
            endcase
          end
        end
        hlp_pkg::ST_DISCW: begin
          if (!rxFrame.cmd && (rxFrame.kind == hlp_pkg::FR_UA
                               || rxFrame.kind == hlp_pkg::FR_DM)) begin
            d.st = hlp_pkg::ST_DOWN;
            d.t1Run = 1'b0;
          end
        end
        hlp_pkg::ST_DOWN: begin
          if (rxFrame.cmd) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_DM, 1'b0, rxFrame.pf, '0, '0);
          end
        end
        default: begin
          d.st = hlp_pkg::ST_DOWN;
        end
      endcase
    end else if (room) begin
      unique case (q.st)
        hlp_pkg::ST_IDLE: begin
          if (isCaller && openReq) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_SABME, 1'b1, 1'b1, '0, '0);
            d.st = hlp_pkg::ST_SETUP;
            d.retry = '0;
            d.t1Run = 1'b1;
            d.t1Cnt = T1_LOAD;
          end
        end
        hlp_pkg::ST_SETUP: begin
          if (t1Exp) begin
            if (q.retry >= N2_LIM) begin
              d.st = hlp_pkg::ST_DOWN;
              d.t1Run = 1'b0;
            end else begin
              push = 1'b1;
              pushFrame = mkFrame(hlp_pkg::FR_SABME, 1'b1, 1'b1, '0, '0);
              d.retry = q.retry + 1'b1;
              d.t1Cnt = T1_LOAD;
            end
          end
        end
        hlp_pkg::ST_INFO: begin
          if (closeReq) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_DISC, 1'b1, 1'b1, '0, '0);
            d.relPulse = relOnDisc;
            d.st = hlp_pkg::ST_DISCW;
            d.t1Run = 1'b1;
            d.t1Cnt = T1_LOAD;
          end else if (t1Exp) begin
            if (q.retry >= N2_LIM) begin
              push = 1'b1;
              pushFrame = mkFrame(hlp_pkg::FR_DISC, 1'b1, 1'b1, '0, '0);
              d.st = hlp_pkg::ST_DISCW;
            end else begin
              // Oldest unacknowledged frame is sent again
              push = 1'b1;
              pushFrame = mkFrame(hlp_pkg::FR_I, 1'b1, 1'b1, q.va, q.vr);
              d.retry = q.retry + 1'b1;
              d.ackPend = 1'b0;
            end
            d.t1Cnt = T1_LOAD;
          end else if (q.ackPend) begin
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_RR, 1'b0, 1'b0, '0, q.vr);
            d.ackPend = 1'b0;
          end else if (txReqValid && winOpen && !q.peerBusy) begin
            if (txReqLen > n1Max) begin
              d.dropPulse = 1'b1;
            end else begin
              push = 1'b1;
              pushFrame = mkFrame(hlp_pkg::FR_I, 1'b1, 1'b0, q.vs, q.vr);
              d.vs = q.vs + 1'b1;
              if (!q.t1Run) begin
                d.t1Run = 1'b1;
                d.t1Cnt = T1_LOAD;
              end
            end
          end else if (t4Exp && !q.t1Run) begin
            // Keep-alive poll while idle
            push = 1'b1;
            pushFrame = mkFrame(hlp_pkg::FR_RR, 1'b1, 1'b1, '0, q.vr);
            d.t4Cnt = T4_LOAD;
            d.t1Run = 1'b1;
            d.t1Cnt = T1_LOAD;
          end
        end
        hlp_pkg::ST_DISCW: begin
          if (t1Exp) begin
            d.st = hlp_pkg::ST_DOWN;
            d.t1Run = 1'b0;
          end
        end
        hlp_pkg::ST_DOWN: begin
          d.t1Run = 1'b0;
        end
        default: begin
          d.st = hlp_pkg::ST_DOWN;
        end
      endcase
    end
    // Two-entry output buffer
    if (push) begin
      d.buffer[q.wrPtr] = pushFrame;
      d.wrPtr = ~q.wrPtr;
    end
    if (pop) begin
      d.rdPtr = ~q.rdPtr;
    end
    d.count = q.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // hlp_link_ctrl

`default_nettype wire

/* File: dv/hlp_link_props.sv */
// Checker for the link engine: frame kinds sent, replies and link state.
// Assumes it is bound to hlp_link_ctrl and sees only its ports.
`default_nettype none

module hlp_link_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic isCaller,
  input wire logic rxValid,
  input wire hlp_pkg::hlp_rx_s rxFrame,
  input wire logic rxReady,
  input wire logic txValid,
  input wire hlp_pkg::hlp_tx_s txFrame,
  input wire logic linkUp,
  input wire logic linkDown,
  input wire logic bearerRelease
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  logic wasUp_q;
  logic rxTake;
  hlp_pkg::hlp_kind_e rk;
  hlp_pkg::hlp_kind_e tk;
  assign rxTake = rxValid && rxReady;
  assign rk = rxFrame.kind;
  assign tk = txFrame.kind;

  // Marks that set-up already happened since reset
  always_ff @(posedge core_clk) begin
    wasUp_q <= rst ? 1'b0 : (wasUp_q | linkUp | linkDown);
  end

  a_no_sabm: assert property (txValid |-> tk != hlp_pkg::FR_SABM)
    else $error("basic set-up frame sent");
  a_no_rej: assert property (txValid |-> tk != hlp_pkg::FR_REJ)
    else $error("reject frame sent");
  a_called_waits: assert property (txValid && !isCaller |-> tk != hlp_pkg::FR_SABME)
    else $error("called end sent set-up");
  a_frmr_caps: assert property (txValid && tk == hlp_pkg::FR_FRMR |->
    txFrame.frmrCaps == 3'h4)
    else $error("wrong capability bits");
  a_down_final: assert property (linkDown |=> linkDown && !linkUp)
    else $error("left final state");
  a_called_up: assert property (rxTake && rk == hlp_pkg::FR_SABME && rxFrame.cmd
    && !isCaller && !wasUp_q |=> linkUp)
    else $error("set-up not accepted");
  a_sabme_disc: assert property (rxTake && rk == hlp_pkg::FR_SABME && linkUp |->
    ##[1:8] (txValid && tk == hlp_pkg::FR_DISC))
    else $error("no disconnect after set-up in transfer");
  a_sabme_release: assert property (rxTake && rk == hlp_pkg::FR_SABME && linkUp |->
    ##[1:4] bearerRelease)
    else $error("no bearer release");
  a_rej_frmr: assert property (rxTake && rk == hlp_pkg::FR_REJ && linkUp |->
    ##[1:8] (txValid && tk == hlp_pkg::FR_FRMR))
    else $error("reject not answered by frame reject");
  a_frmr_disc: assert property (rxTake && rk == hlp_pkg::FR_FRMR && linkUp |->
    ##[1:8] (txValid && tk == hlp_pkg::FR_DISC))
    else $error("frame reject not answered by disconnect");
  a_ack_soon: assert property (rxTake && rk == hlp_pkg::FR_I && rxFrame.cmd && linkUp |->
    ##[1:8] txValid)
    else $error("no prompt acknowledge");
  a_dm_solicited: assert property (txValid && tk == hlp_pkg::FR_DM |-> linkDown)
    else $error("disconnected mode sent while not down");
  a_release_pulse: assert property (bearerRelease |=> !bearerRelease)
    else $error("release pulse too long");
endmodule // hlp_link_props

bind hlp_link_ctrl hlp_link_props i_props (.core_clk(core_clk), .rst(rst),
  .isCaller(isCaller), .rxValid(rxValid), .rxFrame(rxFrame), .rxReady(rxReady),
  .txValid(txValid), .txFrame(txFrame), .linkUp(linkUp), .linkDown(linkDown),
  .bearerRelease(bearerRelease));

`default_nettype wire

/* File: dv/hlp_peer_model.sv */
// Peer link entity: hands frames to the engine, collects what it sends.
// Assumes one core clock; the bench calls send and sets stall or slow.
`default_nettype none

module hlp_peer_model (
  input wire logic core_clk,
  output logic rxValid,
  output hlp_pkg::hlp_rx_s rxFrame,
  input wire logic rxReady,
  input wire logic txValid,
  input wire hlp_pkg::hlp_tx_s txFrame,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stall = 1'b0;
  logic slow = 1'b0;
  hlp_pkg::hlp_tx_s got[$];

  initial begin
    rxValid = 1'b0;
    rxFrame = '0;
    txReady = 1'b1;
  end

  // Full stall, or accept every other cycle
  always @(posedge core_clk) begin
    txReady <= stall ? 1'b0 : (slow ? ~txReady : 1'b1);
    if (txValid && txReady) got.push_back(txFrame);
  end

  // Holds the frame until taken, then scrambles the idle bus
  task automatic send(input hlp_pkg::hlp_kind_e k, input logic c, input logic p,
                      input hlp_pkg::hlp_seq_t ns, input hlp_pkg::hlp_seq_t nr);
    hlp_pkg::hlp_rx_s f;
    f = '{kind: k, cmd: c, pf: p, ns: ns, nr: nr, lenBits: 16'h0040};
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxFrame <= f;
    do @(posedge core_clk); while (!rxReady);
    rxValid <= 1'b0;
    rxFrame <= ~f;
  endtask
endmodule // hlp_peer_model

`default_nettype wire

/* File: dv/tb_top.sv */
// Bench for the link engine: set-up, transfer, recovery, disconnection.
// Assumes the package, design, checker and peer model are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned T1C = 50;
  localparam int unsigned N2C = 2;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic isCaller = 1'b0;
  logic openReq = 1'b0;
  logic closeReq = 1'b0;
  logic relOnDisc = 1'b0;
  logic txReqValid = 1'b0;
  logic t4Enable = 1'b0;
  logic [15:0] txReqLen = 16'h0080;
  logic relSeen = 1'b0;
  hlp_pkg::hlp_seq_t windowK = 7'h02;
  logic rxValid, rxReady, txReqReady, txValid, txReady;
  logic linkUp, linkDown, bearerRelease, reqDropped;
  hlp_pkg::hlp_rx_s rxFrame;
  hlp_pkg::hlp_tx_s txFrame, got;
  int n_fail = 0;
  int n_checks = 0;

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) relSeen <= rst ? 1'b0 : (relSeen | bearerRelease);

  hlp_link_ctrl #(.T1_CYCLES(T1C), .T4_CYCLES(80), .N2_MAX(N2C)) i_dut (
    .core_clk(core_clk), .rst(rst), .isCaller(isCaller), .openReq(openReq),
    .closeReq(closeReq), .relOnDisc(relOnDisc), .t4Enable(t4Enable), .windowK(windowK),
    .n1Max(16'h0100), .rxValid(rxValid), .rxFrame(rxFrame), .rxReady(rxReady),
    .txReqValid(txReqValid), .txReqLen(txReqLen), .txReqReady(txReqReady),
    .txValid(txValid), .txFrame(txFrame), .txReady(txReady), .linkUp(linkUp),
    .linkDown(linkDown), .bearerRelease(bearerRelease), .reqDropped(reqDropped));

  hlp_peer_model i_peer (.core_clk(core_clk), .rxValid(rxValid), .rxFrame(rxFrame),
    .rxReady(rxReady), .txValid(txValid), .txFrame(txFrame), .txReady(txReady));

  task automatic check(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic expect_tx(input hlp_pkg::hlp_kind_e k);
    int i;
    for (i = 0; i < 300 && i_peer.got.size() == 0; i++) @(posedge core_clk);
    check(i_peer.got.size() > 0, "no frame sent");
    got = (i_peer.got.size() > 0) ? i_peer.got.pop_front() : '0;
    check(got.kind === k, "unexpected frame kind");
  endtask

  task automatic reset_dut(input logic caller);
    @(posedge core_clk);
    rst <= 1'b1;
    isCaller <= caller;
    relOnDisc <= 1'b0;
    i_peer.stall <= 1'b0;
    i_peer.slow <= 1'b0;
    t4Enable <= 1'b0;
    txReqLen <= 16'h0080;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    i_peer.got.delete();
  endtask

  task automatic link_called;
    reset_dut(1'b0);
    openReq <= 1'b1;
    repeat (10) @(posedge core_clk);
    check(i_peer.got.size() == 0 && linkUp === 1'b0, "called end opened");
    openReq <= 1'b0;
    i_peer.send(hlp_pkg::FR_SABME, 1'b1, 1'b1, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_UA);
    check(linkUp === 1'b1, "link not up");
  endtask

  task automatic t_caller;
    reset_dut(1'b1);
    openReq <= 1'b1;
    expect_tx(hlp_pkg::FR_SABME);
    openReq <= 1'b0;
    i_peer.send(hlp_pkg::FR_UA, 1'b0, 1'b1, 7'h00, 7'h00);
    repeat (3) @(posedge core_clk);
    check(linkUp === 1'b1, "caller link not up");
  endtask

  task automatic t_transfer;
    link_called();
    i_peer.slow <= 1'b1;
    i_peer.send(hlp_pkg::FR_I, 1'b1, 1'b0, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_RR);
    check(got.nr === 7'h01, "ack count");
    i_peer.send(hlp_pkg::FR_I, 1'b0, 1'b1, 7'h01, 7'h00);
    expect_tx(hlp_pkg::FR_RR);
    check(got.nr === 7'h02, "final response not taken");
    i_peer.send(hlp_pkg::FR_I, 1'b1, 1'b0, 7'h03, 7'h00);
    expect_tx(hlp_pkg::FR_SREJ);
    check(got.nr === 7'h02, "selective reject count");
    i_peer.send(hlp_pkg::FR_REJ, 1'b1, 1'b0, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_FRMR);
    check(got.frmrCaps === 3'h4, "capability bits");
  endtask

  task automatic t_buffer;
    link_called();
    i_peer.stall <= 1'b1;
    i_peer.send(hlp_pkg::FR_REJ, 1'b1, 1'b0, 7'h00, 7'h00);
    i_peer.send(hlp_pkg::FR_REJ, 1'b1, 1'b0, 7'h00, 7'h00);
    @(negedge core_clk);
    check(rxReady === 1'b0, "full buffer not refusing");
    i_peer.stall <= 1'b0;
    expect_tx(hlp_pkg::FR_FRMR);
    expect_tx(hlp_pkg::FR_FRMR);
  endtask

  task automatic t_window;
    int n;
    link_called();
    n = 0;
    txReqValid <= 1'b1;
    repeat (20) begin
      @(posedge core_clk);
      if (txReqValid && txReqReady === 1'b1) n++;
    end
    txReqValid <= 1'b0;
    check(n == 2, "window not kept");
    expect_tx(hlp_pkg::FR_I);
    check(got.ns === 7'h00, "first send count");
    expect_tx(hlp_pkg::FR_I);
    check(got.ns === 7'h01, "second send count");
    repeat (N2C) begin
      expect_tx(hlp_pkg::FR_I);
      check(got.ns === 7'h00 && got.pf === 1'b1, "retry frame");
    end
    expect_tx(hlp_pkg::FR_DISC);
    repeat (T1C + 10) @(posedge core_clk);
    check(linkDown === 1'b1, "not down after retries");
  endtask

  task automatic t_sabme_info;
    link_called();
    i_peer.send(hlp_pkg::FR_SABME, 1'b1, 1'b1, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_DISC);
    repeat (4) @(posedge core_clk);
    check(got.cmd === 1'b1 && relSeen === 1'b1, "no command or release");
    i_peer.send(hlp_pkg::FR_UA, 1'b0, 1'b1, 7'h00, 7'h00);
    repeat (3) @(posedge core_clk);
    check(linkDown === 1'b1, "not down");
    i_peer.send(hlp_pkg::FR_SABME, 1'b1, 1'b1, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_DM);
    check(got.cmd === 1'b0 && linkUp === 1'b0, "set-up again");
  endtask

  task automatic t_frmr_close;
    link_called();
    i_peer.send(hlp_pkg::FR_FRMR, 1'b0, 1'b0, 7'h00, 7'h00);
    expect_tx(hlp_pkg::FR_DISC);
    link_called();
    relOnDisc <= 1'b1;
    closeReq <= 1'b1;
    expect_tx(hlp_pkg::FR_DISC);
    closeReq <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(relSeen === 1'b1, "no release after local disconnect");
  endtask

  // Oversize request dropped, then keep-alive poll and its answer
  task automatic t_options;
    link_called();
    txReqLen <= 16'h0200;
    txReqValid <= 1'b1;
    do @(posedge core_clk); while (txReqReady !== 1'b1);
    txReqValid <= 1'b0;
    @(negedge core_clk);
    check(reqDropped === 1'b1, "oversize request not dropped");
    @(negedge core_clk);
    check(reqDropped === 1'b0 && i_peer.got.size() == 0, "oversize frame sent");
    @(posedge core_clk);
    t4Enable <= 1'b1;
    expect_tx(hlp_pkg::FR_RR);
    check(got.cmd === 1'b1 && got.pf === 1'b1, "no keep-alive poll");
    i_peer.send(hlp_pkg::FR_RR, 1'b0, 1'b1, 7'h00, 7'h00);
    repeat (T1C + 10) @(posedge core_clk);
    check(i_peer.got.size() == 0 && linkUp === 1'b1, "answered poll resent");
  endtask

  initial begin
    t_caller();
    t_transfer();
    t_buffer();
    t_window();
    t_sabme_info();
    t_frmr_close();
    t_options();
    end_of_test();
  end

  initial begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
